// ==== hdl/ircm_defines.vh ====
// Constants for the infrared carrier modulator control block
`ifndef IRCM_DEFINES_VH
`define IRCM_DEFINES_VH
// Byte addresses of the registers, one aligned word each
`define IRCM_ADDR_CTRL_STATUS  8'h50
`define IRCM_ADDR_HIGH_NIBBLES 8'h54
`define IRCM_ADDR_MARK_LOW     8'h58
`define IRCM_ADDR_SPACE_LOW    8'h5c
// Printed offsets are not all multiples of four: word address = index * 4
`define IRCM_IDX_CTRL_STATUS   8'h14
`define IRCM_IDX_HIGH_NIBBLES  8'h15
`define IRCM_IDX_MARK_LOW      8'h16
`define IRCM_IDX_SPACE_LOW     8'h17
// Control/status field positions
`define IRCM_BIT_ENABLE        0
`define IRCM_BIT_IRQ_EN        1
`define IRCM_BIT_MODE          2
`define IRCM_BIT_BASEBAND      3
`define IRCM_BIT_EXT_SPACE     4
`define IRCM_BIT_EXT_MASK      5
`define IRCM_BIT_HALF_RATE     6
`define IRCM_BIT_EOC           7
`define IRCM_CTRL_RESET        8'h00
// Timing: time mode steps every eight oscillator clocks
`define IRCM_TIME_DIV          4'h8
`define IRCM_CNT_W             12
`endif

// ==== hdl/ircm_prescale.v ====
// Time baseband_enable prescaler for the modulator tick
`timescale 1ns/1ps
module ircm_prescale (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_run,
  input  wire i_fsk_mode,
  input  wire i_carrier_period,
  input  wire i_half_rate,
  output reg  o_tick
);
`include "ircm_defines.vh"
  reg [3:0] div_count;
  reg       half_phase;
  wire      baseband_enable_tick;

  assign baseband_enable_tick = i_fsk_mode ? i_carrier_period :
                     (div_count == (`IRCM_TIME_DIV - 4'h1));

  always @(posedge i_ref_clk) begin
    if (i_rst || !i_run) begin
      div_count  <= 4'h0;
      half_phase <= 1'b0;
      o_tick     <= 1'b0;
    end else begin
      if (div_count == (`IRCM_TIME_DIV - 4'h1))
        div_count <= 4'h0;
      else
        div_count <= div_count + 4'h1;
      // Every other baseband_enable tick passes when halving the rate
      if (baseband_enable_tick)
        half_phase <= ~half_phase;
      o_tick <= baseband_enable_tick && (!i_half_rate || half_phase);
    end
  end
endmodule // ircm_prescale

// ==== hdl/ircm_modulator.v ====
// Infrared carrier modulator: registers, mark/space counter and output select
// How it works
// - End-of-cycle flag sets when the complement of the counter's next value equals the space compare value.
// - Flag clears on status read followed by mark-low or space-low access.
// - Half-rate bit passes every other tick, doubling mark and space.
// - External mask bit blocks IRQ and port B interrupts when set.
// - Control register holds an extended-space enable bit.
// - Baseband forces carrier high: output one in mark, zero in space.
// - Mode bit zero selects time mode, one selects FSK; resets to time.
// - Interrupt request raised while flag set and interrupt enable set.
// - Enable starts carrier and modulator running cycle after cycle.
// - Disable finishes current cycle, then hands the output to the software latch.
// - Reset clears control/status; period buffers keep their contents.
// - Twelve-bit mark and space buffers reached through three byte registers.
// - High-nibble register: mark bits 11-8 high, space bits 11-8 low.
// - Low bytes hold mark bits 7-0 and space bits 7-0.
// - Output pin follows modulator while a cycle runs, else the software latch.
// - Idle mode leaves an enabled modulator running.
// - Pending or new cycle interrupt wakes the chip from idle.
// - Stop mode halts the sequencer and blocks writes; the prescaler count clears and read data still loads.
// - Enable loads compare and counter and opens gate; underflow closes it.
// - Time mode counts in units of eight oscillator clocks.
// - FSK mode counts carrier periods and swaps time pairs per mark end.
// - Extended space turns following periods entirely into space.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ircm_modulator (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hsel,
  input  wire        i_hready,
  output wire [31:0] o_hrdata,
  output wire        o_hreadyout,
  output wire        o_hresp,
  input  wire        i_carrier,
  input  wire        i_carrier_period,
  input  wire        i_sw_latch,
  input  wire        i_idle_mode,
  input  wire        i_stop_mode,
  input  wire        i_ext_irq,
  input  wire        i_portb_irq,
  output reg         o_infrared_output_pin,
  output wire        o_carrier_enable,
  output reg         o_carrier_swap,
  output wire        o_irq,
  output wire        o_ext_irq,
  output wire        o_portb_irq,
  output wire        o_wake
);
`include "ircm_defines.vh"
  // Power modes: idle only feeds the wake output here, sequencer and bus keep running;
  // stop freezes the sequencer, the pin and register writes, though read data still
  // loads and the prescaler count restarts from zero when stop ends.

  // --------------------------------------------------------------------------
  // Modulator states
  // --------------------------------------------------------------------------
  // One-hot codes; an illegal code falls back to off through the default
  // branch, which ends any transmission cleanly.
  localparam [2:0] ST_OFF   = 3'b001;
  localparam [2:0] ST_MARK  = 3'b010;
  localparam [2:0] ST_SPACE = 3'b100;

  reg [7:0]  ctrl;
  reg        eoc_flag;
  reg        status_read_armed;
  reg [11:0] mark_buffer;
  reg [11:0] space_buffer;
  reg [11:0] space_compare_register;
  reg [11:0] down_count;
  reg [2:0]  state;
  reg        ext_space_period;
  reg        dp_active;
  reg        dp_write;
  reg [7:0]  dp_index;
  reg [31:0] rdata;
  reg        eoc_event;

  wire       modulator_carrier_enable = ctrl[`IRCM_BIT_ENABLE];
  wire       cycle_irq_enable         = ctrl[`IRCM_BIT_IRQ_EN];
  wire       fsk_mode                 = ctrl[`IRCM_BIT_MODE];
  wire       baseband_enable          = ctrl[`IRCM_BIT_BASEBAND];
  wire       extended_space_enable    = ctrl[`IRCM_BIT_EXT_SPACE];
  wire       external_irq_mask        = ctrl[`IRCM_BIT_EXT_MASK];
  wire       half_rate_prescale       = ctrl[`IRCM_BIT_HALF_RATE];
  wire       running                  = (state != ST_OFF) && !i_stop_mode;
  wire       tick;
  wire       addr_phase;
  wire       match_now;
  wire       underflow_now;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Maps a word-aligned byte address back to the register index
  function [7:0] ircm_index;
    input [31:0] addr;
    begin
      ircm_index = addr[9:2];
    end
  endfunction

  function ircm_is_mapped;
    input [7:0] idx;
    begin
      ircm_is_mapped = (idx == `IRCM_IDX_CTRL_STATUS) ||
                       (idx == `IRCM_IDX_HIGH_NIBBLES) ||
                       (idx == `IRCM_IDX_MARK_LOW) ||
                       (idx == `IRCM_IDX_SPACE_LOW);
    end
  endfunction

  // Low mark or low space byte: the accesses that finish the clearing
  // sequence of the end-of-cycle flag
  function ircm_is_low_byte;
    input [7:0] idx;
    begin
      ircm_is_low_byte = (idx == `IRCM_IDX_MARK_LOW) ||
                         (idx == `IRCM_IDX_SPACE_LOW);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // --------------------------------------------------------------------------
  assign addr_phase  = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata;
  // Every access fits one cycle, so the slave never stretches a transfer;
  // unmapped offsets read zero and take writes silently rather than erroring.

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      dp_active <= 1'b0;
      dp_write  <= 1'b0;
      dp_index  <= 8'h00;
    end else begin
      dp_active <= addr_phase && ircm_is_mapped(ircm_index(i_haddr));
      dp_write  <= i_hwrite;
      dp_index  <= ircm_index(i_haddr);
    end
  end

  // Read data registered at the address phase, so it stands in the data phase
  // and holds until the next read address; writes leave it untouched.
  // Reading has no side effect on the data; only the status read arms a clear.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite) begin
      case (ircm_index(i_haddr))
        `IRCM_IDX_CTRL_STATUS:  rdata <= {24'h00_0000, eoc_flag, ctrl[6:0]};
        `IRCM_IDX_HIGH_NIBBLES: rdata <= {24'h00_0000, mark_buffer[11:8],
                                          space_buffer[11:8]};
        `IRCM_IDX_MARK_LOW:     rdata <= {24'h00_0000, mark_buffer[7:0]};
        `IRCM_IDX_SPACE_LOW:    rdata <= {24'h00_0000, space_buffer[7:0]};
        default:                rdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control register and period buffers
  // --------------------------------------------------------------------------
  // Writes land in the data phase, one cycle after the address was taken.
  // A write issued during stop is lost, not held back for later.
  // Stop mode blocks bus writes too, so nothing here can change
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl <= `IRCM_CTRL_RESET;
    end else if (dp_active && dp_write && !i_stop_mode &&
                 dp_index == `IRCM_IDX_CTRL_STATUS) begin
      // Flag position is not writable mode, baseband etc.
      ctrl <= {1'b0, i_hwdata[6:0]};
    end
  end

  // Buffers have no reset: they survive it by design
  // Refill them from the end-of-cycle interrupt: counter and compare register
  // already hold the previous pair, so new values take effect next cycle.
  always @(posedge i_ref_clk) begin
    if (dp_active && dp_write && !i_stop_mode) begin
      case (dp_index)
        `IRCM_IDX_HIGH_NIBBLES: begin
          mark_buffer[11:8]  <= i_hwdata[7:4];
          space_buffer[11:8] <= i_hwdata[3:0];
        end
        `IRCM_IDX_MARK_LOW:  mark_buffer[7:0]  <= i_hwdata[7:0];
        `IRCM_IDX_SPACE_LOW: space_buffer[7:0] <= i_hwdata[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // End-of-cycle flag and its clearing sequence
  // --------------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      eoc_flag          <= 1'b0;
      status_read_armed <= 1'b0;
    end else begin
      // Only the next mapped access after a status read may clear, so a stray
      // low-byte write after another mapped access leaves the flag alone
      if (dp_active && !i_stop_mode) begin
        // Any mapped access outside stop other than a status read disarms, the low bytes included
        status_read_armed <= !dp_write && (dp_index == `IRCM_IDX_CTRL_STATUS);
      end
      // A new match wins over a clear in the same cycle
      if (eoc_event)
        eoc_flag <= 1'b1;
      else if (dp_active && status_read_armed && !i_stop_mode &&
               ircm_is_low_byte(dp_index))
        eoc_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Mark/space sequencer
  // --------------------------------------------------------------------------
  // The tick is one cycle wide; in FSK mode it follows the carrier-period
  // pulse, so one counter serves both modes
  ircm_prescale u_prescale (
    .i_ref_clk        (i_ref_clk),
    .i_rst            (i_rst),
    .i_run            (running),
    .i_fsk_mode       (fsk_mode),
    .i_carrier_period (i_carrier_period),
    .i_half_rate      (half_rate_prescale),
    .o_tick           (tick)
  );

  // Space compares the value the counter is about to take, so match and reload
  // share one tick and the space lasts exactly space_buffer ticks
  assign match_now     = (~(down_count - 12'h001)) == space_compare_register;
  assign underflow_now = (down_count == 12'h000);

  // Mark counts mark_buffer down to zero; space then runs on into the all-ones
  // range until the complement reaches the compare value
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state                  <= ST_OFF;
      down_count             <= 12'h000;
      space_compare_register <= 12'h000;
      ext_space_period       <= 1'b0;
      eoc_event              <= 1'b0;
      o_carrier_swap         <= 1'b0;
    end else if (!i_stop_mode) begin
      eoc_event      <= 1'b0;
      o_carrier_swap <= 1'b0;
      case (state)
        ST_OFF: begin
          if (modulator_carrier_enable) begin
            space_compare_register <= space_buffer;
            down_count             <= mark_buffer;
            ext_space_period       <= extended_space_enable;
            // Extended space applies from the very first period when already enabled
            state                  <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (tick) begin
            down_count <= down_count - 12'h001;
            if (underflow_now) begin
              state <= ST_SPACE;
              if (fsk_mode)
                o_carrier_swap <= 1'b1;
              // Zero space: counter reads all ones, matches at once
              if (space_compare_register == 12'h000) begin
                eoc_event <= 1'b1;
                state     <= modulator_carrier_enable ? ST_MARK : ST_OFF;
                down_count             <= mark_buffer;
                space_compare_register <= space_buffer;
                ext_space_period       <= extended_space_enable;
              end
            end
          end
        end
        ST_SPACE: begin
          if (tick) begin
            down_count <= down_count - 12'h001;
            if (match_now) begin
              eoc_event              <= 1'b1;
              down_count             <= mark_buffer;
              space_compare_register <= space_buffer;
              ext_space_period       <= extended_space_enable;
              // Disabling takes effect only at the cycle boundary
              state <= modulator_carrier_enable ? ST_MARK : ST_OFF;
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output selection
  // --------------------------------------------------------------------------
  // Baseband forces the carrier high, so mark reads as a steady one
  assign o_carrier_enable = running && !baseband_enable;
  // Pin is registered so mark and space edges follow the clock and no
  // combinational glitch reaches the emitter

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_infrared_output_pin <= 1'b0;
    end else if (!i_stop_mode) begin
      if (state != ST_OFF)
        o_infrared_output_pin <= (state == ST_MARK) && !ext_space_period &&
                                 (baseband_enable || i_carrier);
      else if (modulator_carrier_enable)
        o_infrared_output_pin <= 1'b0;
      else
        o_infrared_output_pin <= i_sw_latch;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts passed to the CPU
  // --------------------------------------------------------------------------
  // Sequencer ignores idle mode, so it keeps running there
  // Wake is a level: a request already pending when idle begins wakes at once.
  // The mask gates only the two external sources, never the cycle request.
  assign o_irq       = eoc_flag && cycle_irq_enable;
  assign o_wake      = i_idle_mode && o_irq;
  assign o_ext_irq   = i_ext_irq && !external_irq_mask;
  assign o_portb_irq = i_portb_irq && !external_irq_mask;

  // Only whole-word transfers reach this block, so the size is not decoded;
  // the reduction just keeps the input visibly consumed
  wire unused_size = |i_hsize;
endmodule // ircm_modulator

// ==== dv/ircm_modulator_props.sv ====
// Port checker for the infrared carrier modulator control block
`timescale 1ns/1ps
`include "ircm_defines.vh"
module ircm_modulator_props (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire [31:0] i_haddr,
  input wire [1:0]  i_htrans,
  input wire        i_hwrite,
  input wire        i_hsel,
  input wire        i_hready,
  input wire        i_ext_irq,
  input wire        i_portb_irq,
  input wire        i_idle_mode,
  input wire        i_stop_mode,
  input wire [31:0] o_hrdata,
  input wire        o_hreadyout,
  input wire        o_hresp,
  input wire        o_infrared_output_pin,
  input wire        o_carrier_swap,
  input wire        o_irq,
  input wire        o_ext_irq,
  input wire        o_portb_irq,
  input wire        o_wake
);
  // -----------------------------------------------------------------
  // Data phase tracker
  // -----------------------------------------------------------------
  reg       dp_v;
  reg [7:0] dp_idx;
  reg       dp_w;
  always @(posedge i_ref_clk) begin
    dp_v   <= i_hsel & i_hready & i_htrans[1];
    dp_idx <= i_haddr[9:2];
    dp_w   <= i_hwrite;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // -----------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------
  bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bus answer not OKAY");
  reset_clear_a: assert property ($past(i_rst) |-> o_hrdata == 32'h0 && !o_irq
    && !o_infrared_output_pin) else $error("outputs not cleared by reset");
  // Only the clearing access, a control write or reset may drop the request
  irq_clear_a: assert property ($fell(o_irq) |-> $past(dp_v) &&
    ($past(dp_idx) == `IRCM_IDX_MARK_LOW || $past(dp_idx) == `IRCM_IDX_SPACE_LOW ||
     ($past(dp_idx) == `IRCM_IDX_CTRL_STATUS && $past(dp_w)))) else $error("irq dropped");
  ext_mask_a: assert property ((o_ext_irq |-> i_ext_irq) and
    (o_portb_irq |-> i_portb_irq)) else $error("masked irq passed without cause");
  wake_a: assert property (o_wake == (i_idle_mode && o_irq)) else $error("wake wrong");
  swap_pulse_a: assert property (o_carrier_swap |=> !o_carrier_swap)
    else $error("swap longer than one cycle");
  stop_hold_a: assert property ($past(i_stop_mode) && !$past(i_rst)
    |-> $stable(o_infrared_output_pin)) else $error("pin moved in stop");
  rdata_upper_a: assert property (o_hrdata[31:8] == 24'h0) else $error("upper read bits set");
  irq_seen_c: cover property ($rose(o_irq));
  swap_seen_c: cover property (o_carrier_swap);
  wake_seen_c: cover property (o_wake);
endmodule // ircm_modulator_props
bind ircm_modulator ircm_modulator_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsel(i_hsel),
  .i_hready(i_hready), .i_ext_irq(i_ext_irq), .i_portb_irq(i_portb_irq),
  .i_idle_mode(i_idle_mode), .i_stop_mode(i_stop_mode), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_infrared_output_pin(o_infrared_output_pin),
  .o_carrier_swap(o_carrier_swap), .o_irq(o_irq), .o_ext_irq(o_ext_irq),
  .o_portb_irq(o_portb_irq), .o_wake(o_wake));

// ==== dv/ircm_emitter_model.sv ====
// Carrier generator and emitter side model feeding the modulator
`timescale 1ns/1ps
module ircm_emitter_model #(
  parameter HALF = 2
) (
  input  wire i_ref_clk,
  input  wire i_gen_on,
  output reg  o_carrier,
  output reg  o_carrier_period
);
  reg [7:0] ph = 8'h00;
  initial o_carrier = 1'b1;
  initial o_carrier_period = 1'b0;
  // A larger HALF gives a slow carrier, so FSK counts stretch out
  always @(posedge i_ref_clk) begin
    ph <= (ph == 2 * HALF - 1) ? 8'h00 : ph + 8'h01;
    o_carrier <= i_gen_on ? (ph < HALF) : 1'b1;
    o_carrier_period <= i_gen_on && (ph == 2 * HALF - 1);
  end
endmodule // ircm_emitter_model

// ==== dv/ircm_modulator_tb_top.sv ====
// Self-checking testbench for the modulator control block
`timescale 1ns/1ps
`include "ircm_defines.vh"
module ircm_modulator_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         sw_latch = 1'b0, idle = 1'b0, stop = 1'b0, ext_irq = 1'b0, pb_irq = 1'b0;
  reg         rd_pend = 1'b0;
  wire [31:0] hrdata;
  wire        hready, carrier, car_per, pin, car_en, swap, irq, o_ext, o_pb, wake;
  logic [31:0] exp_q[$];
  int          n_fail = 0, n_checks = 0, n, i;
  logic [7:0]  d;
  always #2 clk = ~clk;
  ircm_modulator DUT (.i_ref_clk(clk), .i_rst(rst), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_carrier(carrier),
    .i_carrier_period(car_per), .i_sw_latch(sw_latch), .i_idle_mode(idle),
    .i_stop_mode(stop), .i_ext_irq(ext_irq), .i_portb_irq(pb_irq),
    .o_infrared_output_pin(pin), .o_carrier_enable(car_en), .o_carrier_swap(swap),
    .o_irq(irq), .o_ext_irq(o_ext), .o_portb_irq(o_pb), .o_wake(wake));
  ircm_emitter_model #(.HALF(2)) u_emit (.i_ref_clk(clk), .i_gen_on(car_en),
    .o_carrier(carrier), .o_carrier_period(car_per));
  // -----------------------------------------------------------------
  // Checking and bus tasks
  // -----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask
  task bus(input [7:0] idx, input w, input [7:0] v);
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsel   <= 1'b1;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans  <= 2'b00;
    hsel    <= 1'b0;
    hwdata  <= {24'h0, v};
    rd_pend <= !w;
    if (!w) exp_q.push_back({24'h0, v});
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd_pend <= 1'b0;
  endtask
  // Read data is taken at the data phase edge and matched to the oldest note
  always @(posedge clk) if (rd_pend && exp_q.size() > 0) check("hrdata", hrdata, exp_q.pop_front());
  task hi_len(output int h);
    int t;
    t = 0;
    h = 0;
    while (pin !== 1'b1 && t < 3000) begin
      @(posedge clk);
      #1 t++;
    end
    while (pin === 1'b1 && h < 3000) begin
      @(posedge clk);
      #1 h++;
    end
    if (t >= 3000 || h >= 3000) n_fail++;
  endtask
  // Selector: 0 interrupt request, 1 output pin, 2 carrier swap
  task wait_for(input int sel, input logic val);
    int t;
    t = 0;
    while ((sel == 0 ? irq : (sel == 1 ? pin : swap)) !== val && t < 3000) begin
      @(posedge clk);
      #1 t++;
    end
    if (t >= 3000) n_fail++;
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin #40000; n_fail++; close_out; end
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial begin
    n = $urandom(98246);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(`IRCM_IDX_CTRL_STATUS, 0, 8'h00);
    bus(8'h30, 1, 8'h5a);
    bus(8'h30, 0, 8'h00);
    for (i = 0; i < 3; i++) begin
      d = $urandom;
      bus(`IRCM_IDX_HIGH_NIBBLES + i, 1, d);
      bus(`IRCM_IDX_HIGH_NIBBLES + i, 0, d);
    end
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h80);
    bus(`IRCM_IDX_CTRL_STATUS, 0, 8'h00);
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h7e);
    bus(`IRCM_IDX_CTRL_STATUS, 0, 8'h7e);
    ext_irq <= 1'b1;
    pb_irq  <= 1'b1;
    @(posedge clk); #1;
    check("ext_irq", {o_ext, o_pb}, 2'b00);
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h00);
    #1 check("ext_irq", {o_ext, o_pb}, 2'b11);
    // Periods are all loaded while the modulator is still off
    bus(`IRCM_IDX_HIGH_NIBBLES, 1, 8'h00);
    bus(`IRCM_IDX_MARK_LOW, 1, 8'h02);
    bus(`IRCM_IDX_SPACE_LOW, 1, 8'h03);
    for (i = 0; i < 2; i++) begin
      bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h0b | (i << 6));
      hi_len(n);
      hi_len(n);
      check("mark_len", n, 24 << i);
      check("carrier_en", car_en, 1'b0);
      if (i == 0) begin
        idle <= 1'b1;
        wait_for(0, 1'b1);
        #1 check("wake", wake, 1'b1);
        idle <= 1'b0;
        bus(`IRCM_IDX_CTRL_STATUS, 0, 8'h8b);
        bus(`IRCM_IDX_MARK_LOW, 1, 8'h02);
        #1 check("irq", irq, 1'b0);
      end
      // Only the enable bit drops: rate, baseband and mode stay as they were
      bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h0a | (i << 6));
      wait_for(1, 1'b0);
      repeat (120) @(posedge clk);
      #1 check("pin_off", pin, 1'b0);
      // The finished cycle ends with a match, so the flag is up again
      bus(`IRCM_IDX_CTRL_STATUS, 0, 8'h8a | (i << 6));
    end
    sw_latch <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("pin_latch", pin, 1'b1);
    stop <= 1'b1;
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h01);
    stop <= 1'b0;
    bus(`IRCM_IDX_CTRL_STATUS, 0, 8'hca);
    sw_latch <= 1'b0;
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h05);
    repeat (2) @(posedge clk);
    #1 check("carrier_en", car_en, 1'b1);
    wait_for(2, 1'b1);
    check("swap", swap, 1'b1);
    bus(`IRCM_IDX_CTRL_STATUS, 1, 8'h04);
    repeat (200) @(posedge clk);
    close_out;
  end
endmodule // ircm_modulator_tb_top
